// ### rtl/pafs_top.sv
// Port A lines 12 to 23 function select registers and pin multiplexer
// Contract
// - Reserved control bits always read 0 and software writes 0 to them.
// - High bit 14 puts line 23 on port I/O at 0 and on the top byte write strobe at 1.
// - High bit 12 puts line 22 on port I/O at 0 and on the second byte write strobe at 1.
// - High bit 10 puts line 21 on port I/O at 0 and on chip select five at 1.
// - High bit 8 puts line 20 on port I/O at 0 and on chip select four at 1.
// - High bits 7:6 give line 19 port I/O, bus grant ack or DMA ack 1; 11 is never written.
// - High bits 5:4 give line 18 port I/O, bus request input or DMA ack 0; 11 is never written.
// - High bit 2 puts line 17 on port I/O at 0 and on the wait request input at 1.
// - High bits 1:0 give line 16 port I/O at 00 and debug trace sync at 11; 01 and 10 unused.
// - Middle bit 14 puts line 15 on port I/O at 0 and on the system clock output at 1.
// - Middle bit 12 puts line 14 on port I/O at 0 and on the read strobe at 1.
// - Middle bit 10 puts line 13 on port I/O at 0 and on the upper byte write strobe at 1.
// - Middle bit 8 puts line 12 on port I/O at 0 and on the lower byte write strobe at 1.
// - Line 15 mode resets to 1 when booting external-expansion with program memory off.
`timescale 1ns/1ps
`default_nettype none
module pafs_top
    import pafs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  boot_ext_exp_i,
    input  wire logic                  boot_rom_off_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [PAFS_LINES-1:0] port_out_i,
    input  wire logic [PAFS_LINES-1:0] port_oe_i,
    output logic      [PAFS_LINES-1:0] port_in_o,
    input  wire pafs_alt_out_s         alt_out_i,
    output pafs_alt_in_s               alt_in_o,
    input  wire logic [PAFS_LINES-1:0] pad_in_i,
    output logic      [PAFS_LINES-1:0] pad_out_o,
    output logic      [PAFS_LINES-1:0] pad_oe_o
);
    if (ADDR_W < 8) begin : g_chk
        $error("pafs_top: ADDR_W must be at least 8");
    end

    logic [15:0] high_q, high_d;
    logic [15:0] mid_q, mid_d;
    logic [15:0] low_q, low_d;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [PAFS_LINES-1:0] pout_q, poe_q, pin_q;
    pafs_alt_in_s          ain_q;

    // Byte-lane merge of a write into a 16-bit control register
    function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
                                          input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] v;
        v = cur;
        if (sel[0]) begin
            v[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & mask;
    endfunction

    // Pad drive for one line: {out, oe}
    function automatic logic [1:0] drive(input logic alt, input logic a_o, input logic a_oe,
                                         input logic p_o, input logic p_oe);
        return alt ? {a_o, a_oe} : {p_o, p_oe};
    endfunction

    wire         req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire [7:0]   ofs     = wb_adr_i[7:0];
    wire         hit_hi  = (ofs == PAFS_OFS_HIGH);
    wire         hit_mid = (ofs == PAFS_OFS_MID);
    wire         hit_low = (ofs == PAFS_OFS_LOW);
    wire         upper_z = (wb_adr_i >> 8) == '0;
    wire         wr      = req & wb_we_i & upper_z;
    wire [15:0]  rsel    = !upper_z ? 16'h0000 :
                           hit_hi   ? high_q :
                           hit_mid  ? mid_q :
                           hit_low  ? low_q : 16'h0000;

    assign high_d = (wr && hit_hi)  ? merge(high_q, wb_dat_i, wb_sel_i, PAFS_MASK_HIGH) : high_q;
    assign mid_d  = (wr && hit_mid) ? merge(mid_q, wb_dat_i, wb_sel_i, PAFS_MASK_MID) : mid_q;
    assign low_d  = (wr && hit_low) ? merge(low_q, wb_dat_i, wb_sel_i, PAFS_MASK_LOW) : low_q;

    // Mode decode per line
    wire [1:0] md19 = high_q[PAFS_B_L19+1:PAFS_B_L19];
    wire [1:0] md18 = high_q[PAFS_B_L18+1:PAFS_B_L18];
    wire [1:0] md16 = high_q[PAFS_B_L16+1:PAFS_B_L16];
    wire       sel23 = high_q[PAFS_B_L23];
    wire       sel22 = high_q[PAFS_B_L22];
    wire       sel21 = high_q[PAFS_B_L21];
    wire       sel20 = high_q[PAFS_B_L20];
    wire       back19 = (md19 == PAFS_MD_ALT1);
    wire       drak19 = (md19 == PAFS_MD_ALT2);
    wire       breq18 = (md18 == PAFS_MD_ALT1);
    wire       drak18 = (md18 == PAFS_MD_ALT2);
    wire       wait17 = high_q[PAFS_B_L17];
    wire       sync16 = (md16 == PAFS_MD_ALT3);
    wire       sel15 = mid_q[PAFS_B_L15];
    wire       sel14 = mid_q[PAFS_B_L14];
    wire       sel13 = mid_q[PAFS_B_L13];
    wire       sel12 = mid_q[PAFS_B_L12];
    wire       alt19 = back19 | drak19;
    wire       o19   = back19 ? alt_out_i.bus_grant_ack : alt_out_i.dma_ack_channel1;
    wire       o18   = alt_out_i.dma_ack_channel0;

    wire [1:0] d23 = drive(sel23, alt_out_i.top_byte_write_strobe, 1'b1,
                           port_out_i[11], port_oe_i[11]);
    wire [1:0] d22 = drive(sel22, alt_out_i.second_byte_write_strobe, 1'b1,
                           port_out_i[10], port_oe_i[10]);
    wire [1:0] d21 = drive(sel21, alt_out_i.chip_select_five, 1'b1,
                           port_out_i[9], port_oe_i[9]);
    wire [1:0] d20 = drive(sel20, alt_out_i.chip_select_four, 1'b1,
                           port_out_i[8], port_oe_i[8]);
    wire [1:0] d19 = drive(alt19, o19, 1'b1, port_out_i[7], port_oe_i[7]);
    // Bus request is an input: pad not driven in that mode
    wire [1:0] d18 = drive(breq18 | drak18, o18, drak18, port_out_i[6], port_oe_i[6]);
    wire [1:0] d17 = drive(wait17, 1'b0, 1'b0, port_out_i[5], port_oe_i[5]);
    wire [1:0] d16 = drive(sync16, alt_out_i.debug_trace_sync_out,
                           alt_out_i.debug_trace_sync_oe, port_out_i[4], port_oe_i[4]);
    wire [1:0] d15 = drive(sel15, alt_out_i.system_clock, 1'b1, port_out_i[3], port_oe_i[3]);
    wire [1:0] d14 = drive(sel14, alt_out_i.read_strobe, 1'b1, port_out_i[2], port_oe_i[2]);
    wire [1:0] d13 = drive(sel13, alt_out_i.upper_byte_write_strobe, 1'b1,
                           port_out_i[1], port_oe_i[1]);
    wire [1:0] d12 = drive(sel12, alt_out_i.lower_byte_write_strobe, 1'b1,
                           port_out_i[0], port_oe_i[0]);

    wire [23:0] dall = {d23, d22, d21, d20, d19, d18, d17, d16, d15, d14, d13, d12};
    logic [PAFS_LINES-1:0] pout_d, poe_d;
    always_comb begin
        for (int i = 0; i < PAFS_LINES; i++) begin
            pout_d[i] = dall[2*i+1];
            poe_d[i]  = dall[2*i];
        end
    end

    wire [PAFS_LINES-1:0] alt_sel = {sel23, sel22, sel21, sel20, alt19, breq18 | drak18,
                                     wait17, sync16, sel15, sel14, sel13, sel12};
    // Port sees a pin only in port mode
    wire [PAFS_LINES-1:0] pin_d = pad_in_i & ~alt_sel;

    pafs_alt_in_s ain_d;
    assign ain_d.bus_request_input   = breq18 ? pad_in_i[6] : PAFS_IDLE_LOW_ACT;
    assign ain_d.wait_request        = wait17 ? pad_in_i[5] : PAFS_IDLE_LOW_ACT;
    assign ain_d.debug_trace_sync_in = sync16 ? pad_in_i[4] : PAFS_IDLE_SYNC;

    // Boot-mode dependent reset values of the strobe and clock fields
    wire [15:0] high_rst = PAFS_RST_ZERO
                         | ({15'h0000, boot_ext_exp_i} << PAFS_B_L23)
                         | ({15'h0000, boot_ext_exp_i} << PAFS_B_L22);
    wire [15:0] mid_rst  = PAFS_RST_ZERO
                         | ({15'h0000, boot_ext_exp_i & boot_rom_off_i} << PAFS_B_L15)
                         | ({15'h0000, boot_ext_exp_i} << PAFS_B_L14)
                         | ({15'h0000, boot_ext_exp_i} << PAFS_B_L13)
                         | ({15'h0000, boot_ext_exp_i} << PAFS_B_L12);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_q <= high_rst;
            mid_q  <= mid_rst;
            low_q  <= PAFS_RST_ZERO;
        end else begin
            high_q <= high_d;
            mid_q  <= mid_d;
            low_q  <= low_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= {16'h0000, rsel};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pout_q <= '0;
            poe_q  <= '0;
            pin_q  <= '0;
            ain_q  <= '{PAFS_IDLE_LOW_ACT, PAFS_IDLE_LOW_ACT, PAFS_IDLE_SYNC};
        end else begin
            pout_q <= pout_d;
            poe_q  <= poe_d;
            pin_q  <= pin_d;
            ain_q  <= ain_d;
        end
    end

    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;
    assign pad_out_o = pout_q;
    assign pad_oe_o  = poe_q;
    assign port_in_o = pin_q;
    assign alt_in_o  = ain_q;
endmodule
`default_nettype wire

// ### rtl/pafs_pkg.sv
// Constants and types of the port A upper pin function select block
package pafs_pkg;
    localparam int          PAFS_REG_W      = 16;
    localparam int          PAFS_LINES      = 12;
    localparam int          PAFS_LINE_BASE  = 12;
    // Register byte offsets on the Wishbone bus
    localparam logic [7:0]  PAFS_OFS_HIGH   = 8'h00;
    localparam logic [7:0]  PAFS_OFS_MID    = 8'h04;
    localparam logic [7:0]  PAFS_OFS_LOW    = 8'h08;
    // Writable bits; all others are reserved and read zero
    localparam logic [15:0] PAFS_MASK_HIGH  = 16'h55F7;
    localparam logic [15:0] PAFS_MASK_MID   = 16'h555F;
    localparam logic [15:0] PAFS_MASK_LOW   = 16'hFD75;
    localparam logic [15:0] PAFS_RST_ZERO   = 16'h0000;
    // Field positions, high register
    localparam int          PAFS_B_L23      = 14;
    localparam int          PAFS_B_L22      = 12;
    localparam int          PAFS_B_L21      = 10;
    localparam int          PAFS_B_L20      = 8;
    localparam int          PAFS_B_L19      = 6;
    localparam int          PAFS_B_L18      = 4;
    localparam int          PAFS_B_L17      = 2;
    localparam int          PAFS_B_L16      = 0;
    // Field positions, middle register
    localparam int          PAFS_B_L15      = 14;
    localparam int          PAFS_B_L14      = 12;
    localparam int          PAFS_B_L13      = 10;
    localparam int          PAFS_B_L12      = 8;
    // Two-bit field codes
    localparam logic [1:0]  PAFS_MD_PORT    = 2'h0;
    localparam logic [1:0]  PAFS_MD_ALT1    = 2'h1;
    localparam logic [1:0]  PAFS_MD_ALT2    = 2'h2;
    localparam logic [1:0]  PAFS_MD_ALT3    = 2'h3;
    // Level fed to a peripheral input whose pin is not selected
    localparam logic        PAFS_IDLE_LOW_ACT = 1'b1;
    localparam logic        PAFS_IDLE_SYNC    = 1'b0;

    // Signals driven by the alternate-function peripherals
    typedef struct packed {
        logic top_byte_write_strobe;
        logic second_byte_write_strobe;
        logic chip_select_five;
        logic chip_select_four;
        logic bus_grant_ack;
        logic dma_ack_channel1;
        logic dma_ack_channel0;
        logic debug_trace_sync_out;
        logic debug_trace_sync_oe;
        logic system_clock;
        logic read_strobe;
        logic upper_byte_write_strobe;
        logic lower_byte_write_strobe;
    } pafs_alt_out_s;

    // Pin levels handed to the alternate-function peripherals
    typedef struct packed {
        logic bus_request_input;
        logic wait_request;
        logic debug_trace_sync_in;
    } pafs_alt_in_s;
endpackage

// ### dv/pafs_top_props.sv
// Checker of register bus answers and pin muxing of pafs_top
`timescale 1ns/1ps
`default_nettype none
module pafs_top_props
    import pafs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  boot_ext_exp_i,
    input wire logic                  boot_rom_off_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [ADDR_W-1:0]     wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic [PAFS_LINES-1:0] port_out_i,
    input wire logic [PAFS_LINES-1:0] port_oe_i,
    input wire pafs_alt_out_s         alt_out_i,
    input wire logic [PAFS_LINES-1:0] pad_out_o,
    input wire logic [PAFS_LINES-1:0] pad_oe_o
);
    logic [15:0] h_q;
    logic [15:0] m_q;
    wire         take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         wr   = take & wb_we_i;
    wire         ah   = wb_adr_i == ADDR_W'(PAFS_OFS_HIGH);
    wire         am   = wb_adr_i == ADDR_W'(PAFS_OFS_MID);
    wire [15:0]  bm   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Shadow of the mode registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_q <= boot_ext_exp_i ? 16'h5000 : 16'h0000;
            m_q <= (boot_ext_exp_i ? 16'h1500 : 16'h0000)
                 | (boot_ext_exp_i & boot_rom_off_i ? 16'h4000 : 16'h0000);
        end else begin
            if (wr && ah) h_q <= (h_q & ~bm) | (wb_dat_i[15:0] & bm & PAFS_MASK_HIGH);
            if (wr && am) m_q <= (m_q & ~bm) | (wb_dat_i[15:0] & bm & PAFS_MASK_MID);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    property p_rd; wb_ack_o && !wb_we_i && (ah || am)
        |-> wb_dat_o == {16'h0000, ah ? h_q : m_q}; endproperty
    property p_l23; !$past(rst_i) |-> pad_oe_o[11] == $past(h_q[14] | port_oe_i[11])
        && pad_out_o[11] == $past(h_q[14] ? alt_out_i.top_byte_write_strobe : port_out_i[11]);
    endproperty
    property p_l19; !$past(rst_i) |-> pad_out_o[7] == $past(h_q[7:6] == 2'h1 ?
        alt_out_i.bus_grant_ack : h_q[7:6] == 2'h2 ? alt_out_i.dma_ack_channel1 : port_out_i[7]);
    endproperty
    property p_l18; !$past(rst_i) |->
        pad_oe_o[6] == $past(h_q[5:4] == 2'h2 | (h_q[5:4] != 2'h1 & port_oe_i[6])); endproperty
    property p_l16; !$past(rst_i) |-> pad_oe_o[4]
        == $past(h_q[1:0] == 2'h3 ? alt_out_i.debug_trace_sync_oe : port_oe_i[4]); endproperty
    property p_l15; !$past(rst_i) |->
        pad_out_o[3] == $past(m_q[14] ? alt_out_i.system_clock : port_out_i[3]); endproperty
    property p_l12; !$past(rst_i) |-> pad_oe_o[0] == $past(m_q[8] | port_oe_i[0]); endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a single pulse");
    a_rd: assert property (p_rd) else $error("register read data wrong");
    a_l23: assert property (p_l23) else $error("line 23 mux wrong");
    a_l19: assert property (p_l19) else $error("line 19 mux wrong");
    a_l18: assert property (p_l18) else $error("line 18 drive wrong");
    a_l16: assert property (p_l16) else $error("line 16 drive wrong");
    a_l15: assert property (p_l15) else $error("line 15 mux wrong");
    a_l12: assert property (p_l12) else $error("line 12 drive wrong");
    c_wr: cover property (wb_ack_o && wb_we_i);
    c_dma1: cover property (h_q[7:6] == 2'h2);
    c_clk: cover property (m_q[14]);
endmodule
bind pafs_top pafs_top_props #(.ADDR_W(ADDR_W)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .boot_ext_exp_i(boot_ext_exp_i), .boot_rom_off_i(boot_rom_off_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_out_i(port_out_i),
    .port_oe_i(port_oe_i), .alt_out_i(alt_out_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));
`default_nettype wire

// ### dv/pafs_peer.sv
// Model of the pads and alternate-function peripherals
`timescale 1ns/1ps
`default_nettype none
module pafs_peer
    import pafs_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic [PAFS_LINES-1:0] pad_out_i,
    input  wire logic [PAFS_LINES-1:0] pad_oe_i,
    output pafs_alt_out_s              alt_out_o,
    output logic      [PAFS_LINES-1:0] pad_in_o
);
    logic [15:0] cnt_q = 16'h0000;
    always_ff @(posedge clk_i) begin
        cnt_q <= cnt_q + 16'h0001;
    end
    // Every peripheral output changes at least every second cycle
    assign alt_out_o = pafs_alt_out_s'(cnt_q[13:1] ^ {13{cnt_q[0]}});
    // Undriven pads show a changing pattern, except bit 0 (line 12), which always reads 0
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (cnt_q[11:0] ^ {12{cnt_q[0]}}));
endmodule
`default_nettype wire

// ### dv/pafs_top_bench.sv
// Self-checking bench of the port A upper pin function select block
`timescale 1ns/1ps
`default_nettype none
module pafs_top_bench
    import pafs_pkg::*;
;
    logic          clk = 1'b0, rst = 1'b1, ext = 1'b0, off = 1'b0, cyc = 1'b0, we = 1'b0, ack;
    logic [7:0]    adr = 8'h00, a;
    logic [3:0]    sel = 4'h0;
    logic [31:0]   wdat = 32'h0, rdat;
    logic [11:0]   pout = 12'hA5A, poe = 12'h000, pin, pdo, pde, pad, pe, eo;
    logic [15:0]   rd, d;
    pafs_alt_out_s aout;
    pafs_alt_in_s  ain;
    int            fails = 0, check_count = 0, cycles = 0;
    localparam logic [47:0] STEPS [11] = '{48'h00_5000_000_C00, 48'h00_0500_000_300,
        48'h00_0040_000_080, 48'h00_0090_FFF_FAF, 48'h00_0024_000_040, 48'h00_0004_FFF_FCF,
        48'h00_0003_000_000, 48'h04_5500_000_00F, 48'h04_0000_FFF_FEF, 48'h0C_5500_000_000,
        48'h00_AA08_000_000};
    always #2 clk = ~clk;
    always @(posedge clk) begin
        pout <= ~pout;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            final_report();
        end
    end
    pafs_top dut (.clk_i(clk), .rst_i(rst), .boot_ext_exp_i(ext), .boot_rom_off_i(off),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_out_i(pout), .port_oe_i(poe),
        .port_in_o(pin), .alt_out_i(aout), .alt_in_o(ain), .pad_in_i(pad), .pad_out_o(pdo),
        .pad_oe_o(pde));
    pafs_peer peer (.clk_i(clk), .pad_out_i(pdo), .pad_oe_i(pde), .alt_out_o(aout),
        .pad_in_o(pad));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [15:0] dt,
                      input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {16'h0000, dt};
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat[15:0];
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [15:0] e);
        wb(1'b0, ad, 16'h0000, 4'h3);
        check("mode_reg", e, rd);
    endtask
    task automatic boot(input logic e, input logic o);
        rst <= 1'b1;
        ext <= e;
        off <= o;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic final_report();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        boot(1'b1, 1'b1);
        rchk(8'h04, 16'h5500);
        boot(1'b1, 1'b0);
        rchk(8'h04, 16'h1500);
        boot(1'b0, 1'b0);
        rchk(8'h00, 16'h0000);
        foreach (STEPS[i]) begin
            {a, d, pe, eo} = STEPS[i];
            poe <= pe;
            wb(1'b1, a, d, 4'h3);
            rchk(a, a == 8'h00 ? d & PAFS_MASK_HIGH : a == 8'h04 ? d & PAFS_MASK_MID : 16'h0);
            @(negedge clk);
            check("pad_oe", {4'h0, eo}, {4'h0, pde & 12'hFEF});
            if (pe == 12'h000) check("port_in", 16'h0000, {4'h0, pin & eo});
            @(posedge clk);
        end
        wb(1'b1, 8'h00, 16'h5050, 4'h1);
        rchk(8'h00, 16'h0050);
        wb(1'b1, 8'h00, 16'h5000, 4'h2);
        rchk(8'h00, 16'h5050);
        final_report();
    end
endmodule
`default_nettype wire
